/* File: hw/ulms_top.sv */
// Function
// - error summary set while errored entries queued; zero without fifo; cleared by read
// - all-idle flag needs holding, shift register empty and idle; resets to one
// - neither transmit empty flag rises while a break is being sent
// - holding-empty flag follows holding register or fifo empty; resets to one
// - break flag set on break longer than a character; cleared by status read
// - fifo mode: break loads one zero character tagged with framing fault
// - framing flag reports head character stop bit fault; cleared by status read
// - parity flag for head character; address byte marker in multidrop mode
// - no fifo: overrun when new character arrives before previous read
// - fifo mode: overrun when fifo full; that character is dropped
// - available flag set when character enters buffer or fifo
// - available flag cleared by buffer read or fifo drained
// - line status register read-only, two instance addresses, reset value 60h
// - modem status register read-only at two instance addresses
// - upper modem bits show inverted carrier, alert, peer, clear pins
// - loopback maps control bits 3, 2, 0, 1 onto those status bits
// - carrier change bit set on either edge; cleared by modem status read
// - alert bit set only on alert pin falling edge; cleared by read
// - peer ready change bit set on any change; cleared by read
// - clear to send change bit set on any change; cleared by read
// - loopback disconnects modem inputs, feeds control bits in their place
// - multidrop mode follows the multidrop enable control bit
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "ulms_regs.svh"
module ulms_top #(
  parameter int AW = 12,
  parameter int DEPTH = 16,
  parameter bit PORT_ONE = 1'b0
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [AW-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [AW-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic rx_char_done_in,
  input wire logic rx_parity_bad_in,
  input wire logic rx_stop_bad_in,
  input wire logic rx_break_in,
  input wire logic rx_pop_in,
  input wire logic fifo_enable_in,
  output logic rx_load_out,
  output logic rx_zero_out,
  input wire logic tx_hold_empty_in,
  input wire logic tx_shift_empty_in,
  input wire logic tx_idle_in,
  input wire logic send_break_in,
  input wire logic carrier_present_n_in,
  input wire logic call_alert_n_in,
  input wire logic peer_ready_n_in,
  input wire logic clear_send_n_in,
  output logic term_ready_n_out,
  output logic send_req_n_out,
  output logic loop_aux_a_n_out,
  output logic loop_aux_b_n_out,
  output logic loop_mode_out,
  output logic multi_node_out
);
  import ulms_pkg::*;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [7:0] IDX_MODEM_CTRL_REG = PORT_ONE ? `ULMS_IDX_MCTL1 : `ULMS_IDX_MCTL0;
  localparam logic [7:0] IDX_LSR = PORT_ONE ? `ULMS_IDX_LSR1 : `ULMS_IDX_LSR0;
  localparam logic [7:0] IDX_MSR = PORT_ONE ? `ULMS_IDX_MSR1 : `ULMS_IDX_MSR0;

  // =====================================================
  // address decode
  function automatic ulms_sel_t decode(input logic [AW-1:0] addr);
    ulms_sel_t sel;
    sel = ULMS_SEL_NONE;
    if (addr == AW'({IDX_MODEM_CTRL_REG, 2'b00})) sel = ULMS_SEL_MODEM_CTRL_REG;
    if (addr == AW'({IDX_LSR, 2'b00})) sel = ULMS_SEL_LSR;
    if (addr == AW'({IDX_MSR, 2'b00})) sel = ULMS_SEL_MSR;
    return sel;
  endfunction

  ulms_tag_if #(.DEPTH(DEPTH)) tag ();
  ulms_tag_mem #(.DEPTH(DEPTH)) u_tag_mem (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .tag(tag.mem)
  );

  logic wr_acc_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] modem_ctrl_reg_q, lsr_val, msr_val;
  logic wr_take, rd_take, lsr_rd, msr_rd;
  ulms_sel_t wsel, rsel;
  logic accept, full, load, err_in;
  ulms_tag_t in_tag;
  logic avail_q, ovr_q, par_q, frm_q, brk_q, hold_q, idle_q, err_q;
  logic [CW-1:0] err_cnt_q, err_cnt_d;
  logic [3:0] pin_n, sync1_q, sync2_q, src, lvl_q, delta_q, ev;
  logic [1:0] started_q;
  logic load_q, zero_q;
  logic term_q, req_q, auxa_q, auxb_q, loop_q, multi_q;

  // =====================================================
  // bus slave: address and data taken together, one edge later
  always_comb begin
    wsel = decode(s_axi_awaddr_in);
    rsel = decode(s_axi_araddr_in);
    wr_take = wr_acc_q && s_axi_awvalid_in && s_axi_wvalid_in;
    rd_take = arready_q && s_axi_arvalid_in;
    lsr_rd = rd_take && rsel == ULMS_SEL_LSR;
    msr_rd = rd_take && rsel == ULMS_SEL_MSR;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_acc_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `ULMS_RESP_OKAY;
    end else begin
      wr_acc_q <= s_axi_awvalid_in && s_axi_wvalid_in && !wr_acc_q && !bvalid_q;
      if (wr_take) begin
        bvalid_q <= 1'b1;
        bresp_q <= (wsel == ULMS_SEL_NONE) ? `ULMS_RESP_SLVERR : `ULMS_RESP_OKAY;
      end else if (s_axi_bready_in) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= `ULMS_RESP_OKAY;
      rdata_q <= '0;
    end else begin
      arready_q <= s_axi_arvalid_in && !arready_q && !rvalid_q;
      if (rd_take) begin
        rvalid_q <= 1'b1;
        rresp_q <= (rsel == ULMS_SEL_NONE) ? `ULMS_RESP_SLVERR : `ULMS_RESP_OKAY;
        case (rsel)
          ULMS_SEL_MODEM_CTRL_REG: rdata_q <= {24'h000000, modem_ctrl_reg_q};
          ULMS_SEL_LSR: rdata_q <= {24'h000000, lsr_val};
          ULMS_SEL_MSR: rdata_q <= {24'h000000, msr_val};
          default: rdata_q <= '0;
        endcase
      end else if (s_axi_rready_in) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // writes to the status registers are accepted and ignored
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      modem_ctrl_reg_q <= `ULMS_MODEM_CTRL_REG_RESET;
    end else if (wr_take && wsel == ULMS_SEL_MODEM_CTRL_REG && s_axi_wstrb_in[0]) begin
      modem_ctrl_reg_q <= s_axi_wdata_in[7:0] & `ULMS_MODEM_CTRL_REG_MASK;
    end
  end

  // =====================================================
  // receive side events
  always_comb begin
    accept = rx_char_done_in || rx_break_in;
    full = fifo_enable_in && tag.count == FULL;
    load = accept && !full;
    in_tag.brk = rx_break_in;
    in_tag.frm = rx_break_in || rx_stop_bad_in;
    in_tag.par = !rx_break_in && rx_parity_bad_in;
    err_in = in_tag.brk || in_tag.frm || in_tag.par;
    tag.push = load && fifo_enable_in;
    tag.push_tag = in_tag;
    tag.pop = rx_pop_in && fifo_enable_in;
    err_cnt_d = err_cnt_q + CW'(tag.push && err_in)
      - CW'(tag.pop && tag.head_valid && (tag.head != '0));
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      load_q <= 1'b0;
      zero_q <= 1'b0;
    end else begin
      load_q <= load;
      zero_q <= load && rx_break_in;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      avail_q <= 1'b0;
    end else if (load) begin
      avail_q <= 1'b1;
    end else if (rx_pop_in && (!fifo_enable_in || tag.count <= CW'(1))) begin
      avail_q <= 1'b0;
    end
  end

  // new events win over a clearing read in the same cycle
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ovr_q <= 1'b0;
    end else if (accept && (fifo_enable_in ? full : (avail_q && !rx_pop_in))) begin
      ovr_q <= 1'b1;
    end else if (lsr_rd) begin
      ovr_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      brk_q <= 1'b0;
    end else if (rx_break_in) begin
      brk_q <= 1'b1;
    end else if (lsr_rd) begin
      brk_q <= 1'b0;
    end
  end

  // fifo mode reports the head entry, otherwise the buffered character
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      frm_q <= 1'b0;
      par_q <= 1'b0;
    end else begin
      if (fifo_enable_in ? (tag.head_new && tag.head.frm) : (load && in_tag.frm)) begin
        frm_q <= 1'b1;
      end else if (lsr_rd) begin
        frm_q <= 1'b0;
      end
      if (fifo_enable_in ? (tag.head_new && tag.head.par) : (load && in_tag.par)) begin
        par_q <= 1'b1;
      end else if (lsr_rd) begin
        par_q <= 1'b0;
      end
    end
  end

  // mirror is not flushed on fifo disable; the summary is masked instead
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      err_cnt_q <= '0;
      err_q <= 1'b0;
    end else begin
      err_cnt_q <= err_cnt_d;
      if (!fifo_enable_in) begin
        err_q <= 1'b0;
      end else if (err_cnt_d != '0) begin
        err_q <= 1'b1;
      end else if (lsr_rd) begin
        err_q <= 1'b0;
      end
    end
  end

  // =====================================================
  // transmit empty flags
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hold_q <= 1'(`ULMS_LSR_RESET >> `ULMS_LSR_TX_HOLD_EMPTY);
      idle_q <= 1'b1;
    end else begin
      hold_q <= tx_hold_empty_in && !send_break_in;
      idle_q <= tx_hold_empty_in && tx_shift_empty_in && tx_idle_in
        && !send_break_in;
    end
  end

  always_comb begin
    lsr_val = '0;
    lsr_val[`ULMS_LSR_ERR] = err_q && fifo_enable_in;
    lsr_val[`ULMS_LSR_TX_ALL_IDLE] = idle_q;
    lsr_val[`ULMS_LSR_TX_HOLD_EMPTY] = hold_q;
    lsr_val[`ULMS_LSR_BRK] = brk_q;
    lsr_val[`ULMS_LSR_FRM] = frm_q;
    lsr_val[`ULMS_LSR_PAR] = par_q;
    lsr_val[`ULMS_LSR_OVR] = ovr_q;
    lsr_val[`ULMS_LSR_AVL] = avail_q;
  end

  // =====================================================
  // modem status: pins enter at bit 3 (carrier) down to bit 0 (clear)
  assign pin_n = {carrier_present_n_in, call_alert_n_in, peer_ready_n_in, clear_send_n_in};

  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        sync1_q[i] <= 1'b1;
        sync2_q[i] <= 1'b1;
      end else begin
        sync1_q[i] <= pin_n[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  always_comb begin
    if (modem_ctrl_reg_q[`ULMS_MODEM_CTRL_REG_LOOP]) begin
      src = {modem_ctrl_reg_q[3], modem_ctrl_reg_q[2], modem_ctrl_reg_q[0], modem_ctrl_reg_q[1]};
    end else begin
      src = ~sync2_q;
    end
    ev[3] = src[3] ^ lvl_q[3];
    ev[2] = src[2] & ~lvl_q[2];
    ev[1] = src[1] ^ lvl_q[1];
    ev[0] = src[0] ^ lvl_q[0];
    msr_val = {lvl_q, delta_q};
  end

  // a spurious change may latch just after reset; reset loads levels and change bits with zero
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lvl_q <= 4'(`ULMS_MSR_RESET >> 4);
      delta_q <= '0;
    end else begin
      lvl_q <= src;
      delta_q <= (delta_q & ~{4{msr_rd}}) | ev;
    end
  end

  // =====================================================
  // modem control outputs; the four active-low pins go inactive in loopback
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      term_q <= 1'b1;
      req_q <= 1'b1;
      auxa_q <= 1'b1;
      auxb_q <= 1'b1;
      loop_q <= 1'b0;
      multi_q <= 1'b0;
      started_q <= '0;
    end else begin
      loop_q <= modem_ctrl_reg_q[`ULMS_MODEM_CTRL_REG_LOOP];
      term_q <= modem_ctrl_reg_q[`ULMS_MODEM_CTRL_REG_LOOP] || !modem_ctrl_reg_q[`ULMS_MODEM_CTRL_REG_DTR];
      req_q <= modem_ctrl_reg_q[`ULMS_MODEM_CTRL_REG_LOOP] || !modem_ctrl_reg_q[`ULMS_MODEM_CTRL_REG_RTS];
      auxa_q <= modem_ctrl_reg_q[`ULMS_MODEM_CTRL_REG_LOOP] || !modem_ctrl_reg_q[`ULMS_MODEM_CTRL_REG_AUXA];
      auxb_q <= modem_ctrl_reg_q[`ULMS_MODEM_CTRL_REG_LOOP] || !modem_ctrl_reg_q[`ULMS_MODEM_CTRL_REG_AUXB];
      multi_q <= modem_ctrl_reg_q[`ULMS_MODEM_CTRL_REG_MULTI];
      started_q <= (started_q == 2'h3) ? started_q : started_q + 2'h1;
    end
  end

  assign s_axi_awready_out = wr_acc_q;
  assign s_axi_wready_out = wr_acc_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_arready_out = arready_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rresp_out = rresp_q;
  assign s_axi_rdata_out = rdata_q;
  assign rx_load_out = load_q;
  assign rx_zero_out = zero_q;
  assign term_ready_n_out = term_q;
  assign send_req_n_out = req_q;
  assign loop_aux_a_n_out = auxa_q;
  assign loop_aux_b_n_out = auxb_q;
  assign loop_mode_out = loop_q;
  assign multi_node_out = multi_q;

  // =====================================================
  // checks
  a_break_blocks_empty: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    send_break_in |=> !idle_q && !hold_q)
    else $error("transmit empty flag rose during break");
  a_hold_follows: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    tx_hold_empty_in && !send_break_in |=> hold_q)
    else $error("holding empty flag did not follow");
  a_idle_needs_shift: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    started_q != 2'h0 && idle_q |-> $past(tx_shift_empty_in && tx_idle_in))
    else $error("all idle flag set with busy transmitter");
  a_break_sets: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    rx_break_in |=> brk_q)
    else $error("break flag not set");
  a_read_clears_break: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    lsr_rd && !rx_break_in |=> !brk_q && s_axi_rvalid_out)
    else $error("status read did not clear break flag");
  a_err_off_nofifo: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    lsr_rd && !fifo_enable_in |=> !rdata_q[`ULMS_LSR_ERR])
    else $error("error summary read one without fifo");
  a_full_discards: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    rx_char_done_in && fifo_enable_in && tag.count == FULL |=> ovr_q && !rx_load_out)
    else $error("full fifo overrun mishandled");
  a_nofifo_overrun: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    rx_char_done_in && !fifo_enable_in && avail_q && !rx_pop_in |=> ovr_q)
    else $error("overrun not flagged");
  a_load_marks_avail: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    rx_load_out |-> avail_q)
    else $error("loaded character not flagged available");
  a_loop_mapping: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    modem_ctrl_reg_q[`ULMS_MODEM_CTRL_REG_LOOP] && $stable(modem_ctrl_reg_q)
      |=> lvl_q == $past({modem_ctrl_reg_q[3], modem_ctrl_reg_q[2], modem_ctrl_reg_q[0], modem_ctrl_reg_q[1]}))
    else $error("loopback mapping wrong");
  a_pin_levels: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    started_q == 2'h3 && !modem_ctrl_reg_q[`ULMS_MODEM_CTRL_REG_LOOP] && !$past(modem_ctrl_reg_q[`ULMS_MODEM_CTRL_REG_LOOP])
      |-> lvl_q == ~$past(pin_n, 3))
    else $error("modem level not inverted pin after sync");
  a_clear_delta: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    $changed(lvl_q[0]) |-> delta_q[0])
    else $error("clear to send change not latched");
  a_alert_fall: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    delta_q[2] && !$past(delta_q[2]) |-> lvl_q[2] && !$past(lvl_q[2]))
    else $error("alert bit set without falling pin");
endmodule
`default_nettype wire

/* File: hw/ulms_regs.svh */
`ifndef ULMS_REGS_SVH
`define ULMS_REGS_SVH
// =====================================================
// register indices (byte address is four times these)
`define ULMS_IDX_MCTL0 8'hc4
`define ULMS_IDX_LSR0 8'hc5
`define ULMS_IDX_MSR0 8'hc6
`define ULMS_IDX_MCTL1 8'hd4
`define ULMS_IDX_LSR1 8'hd5
`define ULMS_IDX_MSR1 8'hd6
// =====================================================
// line status fields
`define ULMS_LSR_ERR 7
`define ULMS_LSR_TX_ALL_IDLE 6
`define ULMS_LSR_TX_HOLD_EMPTY 5
`define ULMS_LSR_BRK 4
`define ULMS_LSR_FRM 3
`define ULMS_LSR_PAR 2
`define ULMS_LSR_OVR 1
`define ULMS_LSR_AVL 0
`define ULMS_LSR_RESET 8'h60
// =====================================================
// modem control fields
`define ULMS_MODEM_CTRL_REG_DTR 0
`define ULMS_MODEM_CTRL_REG_RTS 1
`define ULMS_MODEM_CTRL_REG_AUXA 2
`define ULMS_MODEM_CTRL_REG_AUXB 3
`define ULMS_MODEM_CTRL_REG_LOOP 4
`define ULMS_MODEM_CTRL_REG_MULTI 5
`define ULMS_MODEM_CTRL_REG_MASK 8'h7f
`define ULMS_MODEM_CTRL_REG_RESET 8'h00
`define ULMS_MSR_RESET 8'h00
// =====================================================
// bus answers
`define ULMS_RESP_OKAY 2'b00
`define ULMS_RESP_SLVERR 2'b10
`endif

/* File: hw/ulms_pkg.sv */
package ulms_pkg;
  typedef struct packed {
    logic brk;
    logic frm;
    logic par;
  } ulms_tag_t;
  typedef enum logic [1:0] {
    ULMS_SEL_NONE = 2'b00,
    ULMS_SEL_MODEM_CTRL_REG = 2'b01,
    ULMS_SEL_LSR = 2'b11,
    ULMS_SEL_MSR = 2'b10
  } ulms_sel_t;
endpackage

/* File: hw/ulms_tag_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface ulms_tag_if #(parameter int DEPTH = 16);
  localparam int CW = $clog2(DEPTH + 1);
  logic push;
  ulms_pkg::ulms_tag_t push_tag;
  logic pop;
  ulms_pkg::ulms_tag_t head;
  logic head_valid;
  logic head_new;
  logic [CW-1:0] count;
  modport ctl(output push, push_tag, pop, input head, head_valid, head_new, count);
  modport mem(input push, push_tag, pop, output head, head_valid, head_new, count);
endinterface
`default_nettype wire

/* File: hw/ulms_tag_mem.sv */
`timescale 1ns/100ps
`default_nettype none
module ulms_tag_mem #(
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  ulms_tag_if.mem tag
);
  import ulms_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  ulms_tag_t mem_q [DEPTH];
  ulms_tag_t head_q;
  logic head_valid_q, head_new_q;
  logic [AW-1:0] wptr_q, rptr_q, nr;
  logic [CW-1:0] cnt_q, cnt_d;
  logic do_push, do_pop;

  // =====================================================
  // pointer arithmetic
  always_comb begin
    do_pop = tag.pop && (cnt_q != '0);
    do_push = tag.push && (cnt_q != FULL);
    cnt_d = cnt_q + CW'(do_push) - CW'(do_pop);
    nr = do_pop ? rptr_q + 1'b1 : rptr_q;
  end

  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem_q[wptr_q] <= tag.push_tag;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
    end else begin
      wptr_q <= do_push ? wptr_q + 1'b1 : wptr_q;
      rptr_q <= nr;
      cnt_q <= cnt_d;
    end
  end

  // =====================================================
  // registered head, bypassed so a push into empty shows at once
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      head_q <= '0;
      head_valid_q <= 1'b0;
      head_new_q <= 1'b0;
    end else begin
      head_q <= (do_push && wptr_q == nr) ? tag.push_tag : mem_q[nr];
      head_valid_q <= cnt_d != '0;
      head_new_q <= (cnt_d != '0) && (do_pop || (do_push && cnt_q == '0));
    end
  end

  assign tag.head = head_q;
  assign tag.head_valid = head_valid_q;
  assign tag.head_new = head_new_q;
  assign tag.count = cnt_q;
endmodule
`default_nettype wire

/* File: verif/ulms_modem.sv */
`timescale 1ns/100ps
`default_nettype none
// =====================================
// far-side modem: drives the four active-low handshake pins
module ulms_modem (
  input wire logic clk_in,
  input wire logic [3:0] level_in,
  output logic carrier_n_out,
  output logic alert_n_out,
  output logic peer_n_out,
  output logic clear_n_out
);
  // pins move just after an edge; no phase relation is promised to the device
  always_ff @(posedge clk_in) begin
    {carrier_n_out, alert_n_out, peer_n_out, clear_n_out} <= ~level_in;
  end
endmodule
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ulms_regs.svh"
module tb;
  localparam logic [11:0] A_MC = 12'(`ULMS_IDX_MCTL0 * 4);
  localparam logic [11:0] A_LS = 12'(`ULMS_IDX_LSR0 * 4);
  localparam logic [11:0] A_MS = 12'(`ULMS_IDX_MSR0 * 4);
  logic clk_in, arst_n_in = 1'b0;
  logic [11:0] aw_addr = 12'h000, ar_addr = 12'h000;
  logic [31:0] w_data = 32'h0;
  logic [3:0] w_strb = 4'hf, lvl = 4'h0;
  logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
  logic rx_done = 1'b0, rx_par = 1'b0, rx_stop = 1'b0, rx_brk = 1'b0, rx_pop = 1'b0;
  logic fifo_en = 1'b0, tx_hold = 1'b1, tx_shift = 1'b1, tx_idle = 1'b1, tx_brk = 1'b0;
  logic awr, wrd, bv, arr, rv, ld, zr, trn, srn, xa, xb, lpm, mn, pc, pa, pp, pl;
  logic [1:0] br, rr;
  logic [31:0] rdat;
  int err_total = 0, cmp_count = 0;
  // =====================================
  // clock, device and far side
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  ulms_top u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .s_axi_awaddr_in(aw_addr),
    .s_axi_awvalid_in(aw_valid), .s_axi_awready_out(awr), .s_axi_wdata_in(w_data),
    .s_axi_wstrb_in(w_strb), .s_axi_wvalid_in(w_valid), .s_axi_wready_out(wrd),
    .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(b_ready),
    .s_axi_araddr_in(ar_addr), .s_axi_arvalid_in(ar_valid), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(r_ready), .rx_char_done_in(rx_done), .rx_parity_bad_in(rx_par),
    .rx_stop_bad_in(rx_stop), .rx_break_in(rx_brk), .rx_pop_in(rx_pop),
    .fifo_enable_in(fifo_en), .rx_load_out(ld), .rx_zero_out(zr),
    .tx_hold_empty_in(tx_hold), .tx_shift_empty_in(tx_shift), .tx_idle_in(tx_idle),
    .send_break_in(tx_brk), .carrier_present_n_in(pc), .call_alert_n_in(pa),
    .peer_ready_n_in(pp), .clear_send_n_in(pl), .term_ready_n_out(trn),
    .send_req_n_out(srn), .loop_aux_a_n_out(xa), .loop_aux_b_n_out(xb),
    .loop_mode_out(lpm), .multi_node_out(mn));
  ulms_modem u_modem (.clk_in(clk_in), .level_in(lvl), .carrier_n_out(pc),
    .alert_n_out(pa), .peer_n_out(pp), .clear_n_out(pl));
  // =====================================
  // checking and bus tasks
  task automatic finish_test();
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 40) begin
      err_total++;
      $display("CHECK FAILED t=%0t bus wait ran out", $time);
      finish_test();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_in);
    aw_addr <= a;
    w_data <= {24'h000000, d};
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (awr) aw_valid <= 1'b0;
      if (wrd) w_valid <= 1'b0;
    end while (bv !== 1'b1 && n < 40);
    b_ready <= 1'b0;
    tmo(n);
    chk(br, er, "write resp");
  endtask
  // a mask leaves out a bit whose value at that very read is left open
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff,
      input logic [1:0] er = `ULMS_RESP_OKAY);
    int n;
    n = 0;
    @(posedge clk_in);
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (arr) ar_valid <= 1'b0;
    end while (rv !== 1'b1 && n < 40);
    r_ready <= 1'b0;
    tmo(n);
    chk(rr, er, "read resp");
    chk(rdat & {24'h000000, m}, {24'h000000, e & m}, "read data");
  endtask
  task automatic rx(input logic p, input logic s, input logic b, input logic l);
    @(posedge clk_in);
    rx_done <= ~b;
    rx_brk <= b;
    rx_par <= p;
    rx_stop <= s;
    @(posedge clk_in);
    rx_done <= 1'b0;
    rx_brk <= 1'b0;
    @(posedge clk_in);
    chk({ld, zr}, {l, l & b}, "rx load");
  endtask
  task automatic pop();
    @(posedge clk_in);
    rx_pop <= 1'b1;
    @(posedge clk_in);
    rx_pop <= 1'b0;
  endtask
  task automatic rst();
    @(posedge clk_in);
    arst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b1;
  endtask
  // =====================================
  // scenarios
  initial begin
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b1;
    rd(A_LS, `ULMS_LSR_RESET);
    rd(A_MS, `ULMS_MSR_RESET);
    wr(A_LS, 8'h00, `ULMS_RESP_OKAY);
    rd(A_LS, 8'h60);
    wr(12'h000, 8'h55, `ULMS_RESP_SLVERR);
    rd(12'h000, 8'h00, 8'hff, `ULMS_RESP_SLVERR);
    tx_hold <= 1'b0;
    rd(A_LS, 8'h00);
    tx_hold <= 1'b1;
    tx_shift <= 1'b0;
    rd(A_LS, 8'h20);
    tx_shift <= 1'b1;
    tx_brk <= 1'b1;
    rd(A_LS, 8'h00);
    tx_brk <= 1'b0;
    rd(A_LS, 8'h60);
    rx(1'b0, 1'b1, 1'b0, 1'b1);
    rd(A_LS, 8'h69);
    rd(A_LS, 8'h61);
    rx(1'b1, 1'b0, 1'b0, 1'b1);
    rd(A_LS, 8'h67);
    rd(A_LS, 8'h61);
    pop();
    rd(A_LS, 8'h60);
    rx(1'b0, 1'b0, 1'b1, 1'b1);
    rd(A_LS, 8'h79);
    rd(A_LS, 8'h61);
    pop();
    for (int i = 3; i >= 0; i--) begin
      lvl[i] <= 1'b1;
      repeat (6) @(posedge clk_in);
      rd(A_MS, {lvl, 4'h0} | (8'h01 << i));
    end
    lvl <= 4'h0;
    repeat (6) @(posedge clk_in);
    rd(A_MS, 8'h0b);
    rd(A_MS, 8'h00);
    wr(A_MC, 8'h1a, `ULMS_RESP_OKAY);
    rd(A_MC, 8'h1a);
    chk({trn, srn, xa, xb, lpm}, 5'h1f, "loop outputs");
    lvl <= 4'hf;
    repeat (6) @(posedge clk_in);
    rd(A_MS, 8'h99);
    rd(A_MS, 8'h90);
    wr(A_MC, 8'h23, `ULMS_RESP_OKAY);
    repeat (6) @(posedge clk_in);
    chk({trn, srn, xa, xb, lpm, mn}, 6'h0d, "control outputs");
    rd(A_MS, 8'hf6);
    // low byte strobe off: control register must keep its value
    w_strb <= 4'he;
    wr(A_MC, 8'h00, `ULMS_RESP_OKAY);
    w_strb <= 4'hf;
    rd(A_MC, 8'h23);
    // fresh start so the entry count begins empty in queued mode
    fifo_en <= 1'b1;
    rst();
    rx(1'b1, 1'b0, 1'b0, 1'b1);
    rd(A_LS, 8'he5);
    rd(A_LS, 8'he1);
    for (int i = 0; i < 15; i++) begin
      rx(1'b0, 1'b0, 1'b0, 1'b1);
    end
    rx(1'b0, 1'b0, 1'b0, 1'b0);
    rd(A_LS, 8'he3);
    for (int i = 0; i < 16; i++) begin
      pop();
    end
    rd(A_LS, 8'he0);
    rd(A_LS, 8'h60);
    rx(1'b0, 1'b0, 1'b1, 1'b1);
    rd(A_LS, 8'hf9);
    rd(A_LS, 8'he1);
    fifo_en <= 1'b0;
    rd(A_LS, 8'h00, 8'h80);
    finish_test();
  end
endmodule
`default_nettype wire
